// ==== rtl/adc_serial_defs.svh ====
// timing counts and command codes for the converter serial/conversion block
// assumes a 125 MHz system clock and a master clock tick derived from it
`ifndef ADC_SERIAL_DEFS_SVH
`define ADC_SERIAL_DEFS_SVH

// system clock period and master clock tick divider (125 MHz / 17)
`define SYS_CLK_NS      8
`define MCLK_DIV        5'h11
// chip-select high time that resets the serial interface
`define CS_RST_NS       25
`define CS_RST_CYC      (((`CS_RST_NS) + (`SYS_CLK_NS) - 1) / (`SYS_CLK_NS))
// master clock periods
`define RST_LOW_TICKS   3'h4
`define STOP_EARLY_TICKS 8'h64
`define STOP_LATE_TICKS 8'h96
`define DATA_READY_N_HIGH_TICKS 16'h0010
`define START_WAIT_TICKS 10'h200
// command byte codes
`define CMD_NOP_CODE    8'h00
`define CMD_RESET_CODE  8'h06
`define CMD_START_CODE  8'h08
`define CMD_STOP_CODE   8'h0A

`endif

// ==== rtl/adc_serial_pkg.sv ====
// types shared by the converter serial/conversion block
// assumes adc_serial_defs.svh is on the include path
`include "adc_serial_defs.svh"

package adc_serial_pkg;

  // pins from the host, carried together through the synchroniser
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic start;
    logic reset_n;
  } host_pins_t;

  typedef enum logic [7:0] {
    CMD_NOP   = `CMD_NOP_CODE,
    CMD_RESET = `CMD_RESET_CODE,
    CMD_START = `CMD_START_CODE,
    CMD_STOP  = `CMD_STOP_CODE
  } cmd_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_IDLE = 3'h2,
    ST_CONV = 3'h4
  } conv_state_t;

endpackage

// ==== rtl/adc_serial_conversion_timing.sv ====
// serial interface and conversion-control timing of the converter
// assumes host pins are asynchronous to I_MCLK; master clock is a tick
`timescale 1ns/10ps
`include "adc_serial_defs.svh"

module adc_serial_conversion_timing #(
  parameter logic [16:0] T_SCIR   = 17'h10004,
  parameter logic [15:0] CONV_LEN = 16'h0400
) (
  // clock and reset
  input  wire logic I_MCLK,
  input  wire logic I_RST,
  // host pins
  input  wire logic I_CS_N,
  input  wire logic I_SCLK,
  input  wire logic I_DIN,
  input  wire logic I_START,
  input  wire logic I_RESET_N,
  // mode straps
  input  wire logic I_TIMEOUT_EN,
  input  wire logic I_CONTINUOUS,
  // shared data / data ready pin
  output logic      O_SHARED_OUT_READY_PIN,
  output logic      O_SHARED_OUT_READY_PIN_OE,
  // status
  output logic      O_DATA_READY_N,
  output logic      O_CONVERTING
);

  adc_serial_pkg::host_pins_t  pin_s1_r, pin_s2_r, pin_q_r, pin_in;
  adc_serial_pkg::conv_state_t state_r;
  logic [4:0]  div_r;
  logic        tick;
  logic        sclk_rise, sclk_fall, start_rise, start_fall;
  logic [2:0]  cs_hi_cnt_r;
  logic [16:0] to_cnt_r;
  logic        iface_rst;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  rx_r, tx_r, cmd_byte;
  logic        in_cmd_r, dout_r, cmd_vld;
  logic [2:0]  rst_lo_cnt_r;
  logic        dev_rst;
  logic [9:0]  wait_cnt_r;
  logic [15:0] conv_cnt_r;
  logic [7:0]  since_fall_r, result_r;
  logic        data_ready_n_n_r, fell_r, start_pend_r, stop_pend_r;
  logic        start_req, stop_req;

  assign pin_in = '{cs_n: I_CS_N, sclk: I_SCLK, din: I_DIN,
                    start: I_START, reset_n: I_RESET_N};

  // two-flop synchroniser; pin_q_r only follows the second stage
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pin_s1_r <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, start: 1'b0,
                    reset_n: 1'b1};
      pin_s2_r <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, start: 1'b0,
                    reset_n: 1'b1};
      pin_q_r  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, start: 1'b0,
                    reset_n: 1'b1};
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_q_r  <= pin_s2_r;
    end
  end

  assign sclk_rise  = pin_s2_r.sclk & ~pin_q_r.sclk;
  assign sclk_fall  = ~pin_s2_r.sclk & pin_q_r.sclk;
  assign start_rise = pin_s2_r.start & ~pin_q_r.start;
  assign start_fall = ~pin_s2_r.start & pin_q_r.start;

  // master clock tick, about 7.35 MHz
  always_ff @(posedge I_MCLK) begin
    if (I_RST || tick) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end
  assign tick = (div_r == `MCLK_DIV - 5'h01);

  always_ff @(posedge I_MCLK) begin
    if (I_RST || !pin_s2_r.cs_n) begin
      cs_hi_cnt_r <= 3'h0;
    end else if (cs_hi_cnt_r != 3'(`CS_RST_CYC)) begin
      cs_hi_cnt_r <= cs_hi_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST || !I_TIMEOUT_EN || sclk_rise || sclk_fall ||
        to_cnt_r >= T_SCIR) begin
      to_cnt_r <= 17'h00000;
    end else if (tick) begin
      to_cnt_r <= to_cnt_r + 17'h00001;
    end
  end

  assign iface_rst = I_RST || dev_rst ||
                     (cs_hi_cnt_r == 3'(`CS_RST_CYC)) ||
                     (I_TIMEOUT_EN && to_cnt_r >= T_SCIR);

  // serial shifter: bits in on falling edge, out on rising edge
  always_ff @(posedge I_MCLK) begin
    if (iface_rst) begin
      bit_cnt_r <= 3'h0;
      rx_r      <= 8'h00;
      tx_r      <= result_r;
      in_cmd_r  <= 1'b0;
      dout_r    <= 1'b0;
    end else if (!pin_s2_r.cs_n) begin
      if (sclk_rise) begin
        in_cmd_r <= 1'b1;
        dout_r   <= tx_r[7];
        tx_r     <= {tx_r[6:0], 1'b0};
      end
      if (sclk_fall) begin
        rx_r      <= {rx_r[6:0], pin_s2_r.din};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          in_cmd_r <= 1'b0;
          tx_r     <= result_r;
        end
      end
    end
  end

  assign cmd_byte = {rx_r[6:0], pin_s2_r.din};
  assign cmd_vld  = !pin_s2_r.cs_n && sclk_fall && bit_cnt_r == 3'h7;

  // shared pin shows data ready between commands
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_SHARED_OUT_READY_PIN    <= 1'b1;
      O_SHARED_OUT_READY_PIN_OE <= 1'b0;
    end else begin
      // a deselected or cut frame falls back to data ready at once
      O_SHARED_OUT_READY_PIN    <= (in_cmd_r && !pin_s2_r.cs_n) ?
                                   dout_r : data_ready_n_n_r;
      O_SHARED_OUT_READY_PIN_OE <= !pin_s2_r.cs_n;
    end
  end

  // reset pin is recognised only after it has been low for 4 ticks
  always_ff @(posedge I_MCLK) begin
    if (I_RST || pin_s2_r.reset_n) begin
      rst_lo_cnt_r <= 3'h0;
    end else if (tick && rst_lo_cnt_r != `RST_LOW_TICKS) begin
      rst_lo_cnt_r <= rst_lo_cnt_r + 3'h1;
    end
  end

  assign dev_rst = (rst_lo_cnt_r == `RST_LOW_TICKS) ||
                   (cmd_vld && cmd_byte == adc_serial_pkg::CMD_RESET);
  assign start_req = start_rise ||
                     (cmd_vld && cmd_byte == adc_serial_pkg::CMD_START);
  assign stop_req  = start_fall ||
                     (cmd_vld && cmd_byte == adc_serial_pkg::CMD_STOP);

  // ticks since data ready last fell, saturating
  always_ff @(posedge I_MCLK) begin
    if (I_RST || (data_ready_n_n_r && state_r == adc_serial_pkg::ST_CONV &&
                  conv_cnt_r == CONV_LEN - 16'h0001 && tick)) begin
      since_fall_r <= 8'h00;
    end else if (tick && since_fall_r != 8'hFF) begin
      since_fall_r <= since_fall_r + 8'h01;
    end
  end

  // conversion control
  always_ff @(posedge I_MCLK) begin
    if (I_RST || dev_rst) begin
      state_r      <= adc_serial_pkg::ST_WAIT;
      wait_cnt_r   <= 10'h000;
      conv_cnt_r   <= 16'h0000;
      data_ready_n_n_r     <= 1'b1;
      fell_r       <= 1'b0;
      start_pend_r <= 1'b0;
      stop_pend_r  <= 1'b0;
      result_r     <= 8'h00;
    end else begin
      case (state_r)
        adc_serial_pkg::ST_WAIT: begin
          if (start_req) begin
            start_pend_r <= 1'b1;
          end else if (stop_req) begin
            start_pend_r <= 1'b0;
          end
          if (tick) begin
            wait_cnt_r <= wait_cnt_r + 10'h001;
            if (wait_cnt_r == `START_WAIT_TICKS - 10'h001) begin
              state_r <= adc_serial_pkg::ST_IDLE;
            end
          end
        end
        adc_serial_pkg::ST_IDLE: begin
          if (start_req || start_pend_r) begin
            data_ready_n_n_r     <= 1'b1;
            conv_cnt_r   <= 16'h0000;
            fell_r       <= 1'b0;
            stop_pend_r  <= 1'b0;
            start_pend_r <= 1'b0;
            state_r      <= adc_serial_pkg::ST_CONV;
          end
        end
        adc_serial_pkg::ST_CONV: begin
          if (start_req) begin
            // restart raises data ready at once
            data_ready_n_n_r    <= 1'b1;
            conv_cnt_r  <= 16'h0000;
            fell_r      <= 1'b0;
            stop_pend_r <= 1'b0;
          end else if (stop_req && fell_r &&
                       since_fall_r < `STOP_LATE_TICKS) begin
            // early stop drops the running conversion
            // the 100..149 window is treated as early too
            state_r <= adc_serial_pkg::ST_IDLE;
          end else begin
            // late stop lets this conversion finish
            if (stop_req) begin
              stop_pend_r <= 1'b1;
            end
            if (tick) begin
              conv_cnt_r <= conv_cnt_r + 16'h0001;
              // rise early enough to stay high 16 ticks
              if (conv_cnt_r == CONV_LEN - `DATA_READY_N_HIGH_TICKS - 16'h0001) begin
                data_ready_n_n_r <= 1'b1;
              end
              if (conv_cnt_r == CONV_LEN - 16'h0001) begin
                data_ready_n_n_r   <= 1'b0;
                fell_r     <= 1'b1;
                result_r   <= result_r + 8'h01;
                conv_cnt_r <= 16'h0000;
                if (!I_CONTINUOUS || stop_pend_r || stop_req) begin
                  state_r <= adc_serial_pkg::ST_IDLE;
                end
              end
            end
          end
        end
        default: begin
          state_r <= adc_serial_pkg::ST_WAIT;
        end
      endcase
    end
  end

  assign O_DATA_READY_N = data_ready_n_n_r;
  assign O_CONVERTING   = state_r[2];

endmodule // adc_serial_conversion_timing

// ==== verification/adc_serial_properties.sv ====
// checker for the converter serial and conversion block
// assumes 17 clock cycles to a master tick
`timescale 1ns/10ps
module adc_serial_properties #(
  parameter logic [16:0] T_SCIR   = 17'h10004,
  parameter logic [15:0] CONV_LEN = 16'h0400
) (
  input wire logic I_MCLK, I_RST, I_CS_N, I_START, I_RESET_N, I_CONTINUOUS,
  input wire logic O_SHARED_OUT_READY_PIN, O_SHARED_OUT_READY_PIN_OE,
  input wire logic O_DATA_READY_N, O_CONVERTING
);
  logic [8:0]  hi_r;
  logic [13:0] rst_age_r;
  logic [11:0] fall_age_r;
  logic        fell_r;
  logic        rdy_q_r;
  wire         rdy_fell = rdy_q_r && !O_DATA_READY_N;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  always_ff @(posedge I_MCLK)
    if (I_RST || !O_DATA_READY_N) hi_r <= 9'h000;
    else if (hi_r != 9'h1FF) hi_r <= hi_r + 9'h001;
  // reset commands are unseen here, so waits after them are judged loosely
  always_ff @(posedge I_MCLK)
    if (I_RST || !I_RESET_N) rst_age_r <= 14'h0000;
    else if (rst_age_r != 14'h3FFF) rst_age_r <= rst_age_r + 14'h0001;
  always_ff @(posedge I_MCLK) begin
    rdy_q_r <= O_DATA_READY_N;
    if (I_RST || rdy_fell) fall_age_r <= 12'h000;
    else if (fall_age_r != 12'hFFF) fall_age_r <= fall_age_r + 12'h001;
    if (I_RST || !O_CONVERTING) fell_r <= 1'b0;
    else if (rdy_fell) fell_r <= 1'b1;
  end
  oe_on_select_a: assert property (
    !I_CS_N [*6] |-> O_SHARED_OUT_READY_PIN_OE) else $error("pin not driven");
  oe_off_idle_a: assert property (
    I_CS_N [*6] |-> !O_SHARED_OUT_READY_PIN_OE) else $error("pin driven");
  pin_shows_ready_a: assert property (
    I_CS_N [*6] ##0 $stable(O_DATA_READY_N)
    |-> O_SHARED_OUT_READY_PIN == O_DATA_READY_N) else $error("pin not ready");
  start_resp_a: assert property (
    $rose(I_START) && !O_CONVERTING && rst_age_r > 14'h2300
    |-> ##[1:40] O_DATA_READY_N && O_CONVERTING) else $error("start ignored");
  ready_high_len_a: assert property (
    $fell(O_DATA_READY_N) |-> hi_r >= 9'h110) else $error("ready high short");
  reset_wait_a: assert property (
    $rose(O_CONVERTING) |-> rst_age_r >= 14'h21EF) else $error("start too soon");
  early_stop_a: assert property (
    $fell(I_START) && I_CONTINUOUS && fell_r && fall_age_r < 12'h9E0
    |-> ##[1:8] !O_CONVERTING ##1 !O_DATA_READY_N) else $error("not stopped");
  late_stop_a: assert property (
    $fell(I_START) && I_CONTINUOUS && fell_r && fall_age_r > 12'hA00
    |-> ##[1:900] $fell(O_DATA_READY_N)) else $error("conversion cut");
  early_c: cover property ($fell(I_START) && fell_r && fall_age_r < 12'h640);
  late_c: cover property ($fell(I_START) && fell_r && fall_age_r > 12'hA00);
  select_c: cover property ($rose(O_SHARED_OUT_READY_PIN_OE));
endmodule // adc_serial_properties

bind adc_serial_conversion_timing adc_serial_properties #(
  .T_SCIR(T_SCIR), .CONV_LEN(CONV_LEN)) adc_serial_properties_i (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_CS_N(I_CS_N), .I_START(I_START),
  .I_RESET_N(I_RESET_N), .I_CONTINUOUS(I_CONTINUOUS),
  .O_SHARED_OUT_READY_PIN(O_SHARED_OUT_READY_PIN),
  .O_SHARED_OUT_READY_PIN_OE(O_SHARED_OUT_READY_PIN_OE),
  .O_DATA_READY_N(O_DATA_READY_N), .O_CONVERTING(O_CONVERTING));

// ==== verification/adc_host_model.sv ====
// host model driving chip select, serial clock and data in,
// and reading back the shared pin on each falling serial clock
// assumes an 8 ns clock; serial clock runs at 160 ns inside frames only
`timescale 1ns/10ps
module adc_host_model (
  // bench clock and shared pin from the block
  input  wire logic       i_clk,
  input  wire logic       i_pin,
  // link to the block
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic            o_din,
  // last byte read back
  output logic [7:0]      o_rx
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
    o_rx   = 8'h00;
  end
  task automatic half();
    repeat (10) @(posedge i_clk);
    #1;
  endtask
  task automatic send(input logic [7:0] b, input int n, input logic hold);
    o_cs_n = 1'b0;
    half();
    for (int k = 7; k > 7 - n; k--) begin
      o_sclk = 1'b1;
      o_din  = b[k];
      half();
      o_rx   = {o_rx[6:0], i_pin};
      o_sclk = 1'b0;
      half();
    end
    // released data line shows the inverse, never a stale bit
    o_din  = ~o_din;
    o_cs_n = ~hold;
  endtask
  // select high 48 ns
  // select is left high; the next send lowers it in a later step
  task automatic cs_pulse();
    @(posedge i_clk);
    #1 o_cs_n = 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
endmodule // adc_host_model

// ==== verification/adc_serial_conversion_timing_test.sv ====
// self-checking bench for the converter serial and conversion block
// assumes the host model and the bound checker are compiled before it
`timescale 1ns/10ps
module adc_serial_conversion_timing_test;
  logic mclk, rst, start, reset_n, tmo_en, cont, conv_q;
  logic cs_n, sclk, din, pin, pin_oe, ready_n, conv;
  logic [7:0] rx;
  logic q[$];
  int   n_errors = 0, total_checks = 0, seed = 32'h5041FC9C;
  always #4 mclk = ~mclk;
  adc_host_model adc_host_model_i (.i_clk(mclk), .i_pin(pin),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .o_rx(rx));
  adc_serial_conversion_timing #(.T_SCIR(17'h00020), .CONV_LEN(16'h00C0))
  adc_serial_conversion_timing_i (.I_MCLK(mclk), .I_RST(rst),
    .I_CS_N(cs_n), .I_SCLK(sclk), .I_DIN(din), .I_START(start),
    .I_RESET_N(reset_n), .I_TIMEOUT_EN(tmo_en), .I_CONTINUOUS(cont),
    .O_SHARED_OUT_READY_PIN(pin), .O_SHARED_OUT_READY_PIN_OE(pin_oe),
    .O_DATA_READY_N(ready_n), .O_CONVERTING(conv));
  task automatic check(input string what, input logic seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    check("notes left", q.size() == 0, 1'b1);
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n * 17) @(posedge mclk);
    #1;
  endtask
  task automatic wait_fall();
    logic prev, hit;
    prev = ready_n;
    hit  = 1'b0;
    for (int k = 0; k < 20000 && !hit; k++) begin
      @(posedge mclk);
      #1;
      hit  = prev && !ready_n;
      prev = ready_n;
    end
    check("ready fall", hit, 1'b1);
  endtask
  // each change of the converting flag takes the oldest note
  always @(negedge mclk)
    if (!rst && conv !== conv_q) begin
      conv_q = conv;
      check("converting", conv, q.size() ? q.pop_front() : ~conv);
    end
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    mclk    = 1'b0;
    rst     = 1'b1;
    start   = 1'b0;
    reset_n = 1'b1;
    tmo_en  = 1'b0;
    cont    = 1'b1;
    conv_q  = 1'b0;
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    check("idle", {pin, pin_oe, ready_n, conv} === 4'b1010, 1'b1);
    // start levels held 4 ticks or more
    // second pass stops inside the 100..149 tick window
    for (int r = 0; r < 2; r++) begin
      start = 1'b1;
      q.push_back(1'b1);
      wait_fall();
      ticks((r ? 100 : 10) + ($random(seed) & 32'h1F));
      q.push_back(1'b0);
      start = 1'b0;
      ticks(8);
      check("held low", ready_n, 1'b0);
      $display("early stop done");
    end
    start = 1'b1;
    q.push_back(1'b1);
    wait_fall();
    ticks(160);
    q.push_back(1'b0);
    start = 1'b0;
    wait_fall();
    $display("late stop done");
    cont = 1'b0;
    q.push_back(1'b1);
    adc_host_model_i.send(adc_serial_pkg::CMD_START, 8, 1'b0);
    // four conversions have completed since reset
    check("tx byte", rx == 8'h04, 1'b1);
    ticks(20);
    q.push_back(1'b0);
    reset_n = 1'b0;
    ticks(5);
    reset_n = 1'b1;
    $display("pin reset done");
    tmo_en = 1'b1;
    adc_host_model_i.send(8'($random(seed)) | 8'h80, 5, 1'b1);
    ticks(40);
    q.push_back(1'b1);
    q.push_back(1'b0);
    adc_host_model_i.send(adc_serial_pkg::CMD_START, 8, 1'b0);
    wait_fall();
    $display("stall time-out done");
    tmo_en = 1'b0;
    adc_host_model_i.send(8'($random(seed)) | 8'h80, 3, 1'b1);
    adc_host_model_i.cs_pulse();
    q.push_back(1'b1);
    adc_host_model_i.send(adc_serial_pkg::CMD_START, 8, 1'b1);
    // one conversion since the pin reset, reloaded by the select pulse
    check("tx reload", rx == 8'h01, 1'b1);
    ticks(20);
    q.push_back(1'b0);
    adc_host_model_i.send(adc_serial_pkg::CMD_RESET, 8, 1'b0);
    ticks(20);
    $display("select pulse done");
    wrap_up();
  end
endmodule // adc_serial_conversion_timing_test
